//--- common/epm_pkg.sv
// shared constants, register map and helpers for the extended parallel port mode control
package epm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned ADDR_W = 13;

    localparam logic [2:0] MODE_STD = 3'h0;
    localparam logic [2:0] MODE_PS2 = 3'h1;
    localparam logic [2:0] MODE_FIFO = 3'h2;
    localparam logic [2:0] MODE_ECP = 3'h3;
    localparam logic [2:0] MODE_EPP = 3'h4;
    localparam logic [2:0] MODE_RSVD = 3'h5;
    localparam logic [2:0] MODE_TEST = 3'h6;
    localparam logic [2:0] MODE_CFG = 3'h7;

    // register indices; byte address is four times the index
    localparam logic [10:0] IDX_DATA = 11'h000;
    localparam logic [10:0] IDX_STATUS = 11'h001;
    localparam logic [10:0] IDX_CTRL = 11'h002;
    localparam logic [10:0] IDX_FIFO = 11'h400;
    localparam logic [10:0] IDX_CFGB = 11'h401;
    localparam logic [10:0] IDX_ECR = 11'h402;
    localparam logic [10:0] IDX_OPT = 11'h403;

    localparam int unsigned ECR_MODE_LSB = 5;
    localparam int unsigned ECR_MISC_LSB = 2;
    localparam int unsigned ECR_FULL_BIT = 1;
    localparam int unsigned ECR_EMPTY_BIT = 0;
    localparam int unsigned CTRL_STROBE_BIT = 0;
    localparam int unsigned CTRL_AUTOFD_BIT = 1;
    localparam int unsigned CTRL_INIT_BIT = 2;
    localparam int unsigned CTRL_SELIN_BIT = 3;
    localparam int unsigned CTRL_DIR_BIT = 5;
    localparam int unsigned OPT_EPP_BIT = 0;

    localparam logic [2:0] ECR_MODE_RST = MODE_STD;
    localparam logic [2:0] ECR_MISC_RST = 3'h0;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic OPT_EPP_RST = 1'b0;
    localparam logic [7:0] CFGA_VALUE = 8'h10;
    localparam logic [3:0] PIN_OUT_RST = 4'h0;
    localparam logic [3:0] PIN_OE_RST = 4'h4;

    localparam logic TAG_CMD = 1'b0;
    localparam logic TAG_DATA = 1'b1;

    localparam int unsigned HS_SETUP_NS = 500;
    localparam int unsigned HS_STROBE_NS = 500;
    localparam int unsigned HS_SETUP_CYC = (HS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HS_STROBE_CYC = (HS_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    function automatic logic epm_is_basic(input logic [2:0] mode);
        return (mode == MODE_STD) || (mode == MODE_PS2);
    endfunction : epm_is_basic
endpackage : epm_pkg

//--- hw/epm_ctrl.sv
// extended parallel port mode control, fifo sequencing and ecp handshake
`timescale 1ns/1ps
module epm_ctrl
    import epm_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 16,
    parameter logic [7:0] CFGB_VALUE = 8'h00
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [epm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pd_i,
    output logic [7:0] pd_o,
    output logic pd_oe,
    output logic [3:0] ctl_o,
    output logic [3:0] ctl_oe,
    input wire logic busy_i,
    input wire logic nack_i,
    input wire logic perror_i,
    input wire logic select_i,
    input wire logic nfault_i,
    output logic epp_active
);
    import epm_pkg::*;

    typedef enum {HS_IDLE, HS_SETUP, HS_STROBE, HS_RELEASE, HS_REV_ACK} epm_hs_state_t;

    epm_hs_state_t st_reg;
    logic [2:0] mode_reg;
    logic [2:0] pend_mode_reg;
    logic pend_valid_reg;
    logic flush_reg;
    logic [2:0] ecr_misc_reg;
    logic [5:0] ctrl_reg;
    logic [7:0] data_reg;
    logic epp_opt_reg;
    logic [7:0] prdata_reg;
    logic cap_empty_reg;
    logic [7:0] last_rd_reg;
    logic [7:0] pd_out_reg;
    logic pd_oe_reg;
    logic strobe_pin_reg;
    logic autofd_pin_reg;
    logic [7:0] timer_reg;

    logic [10:0] idx;
    logic hit;
    logic [7:0] rd_val;
    logic wr_acc;
    logic rd_acc;
    logic dir_eff;
    logic fwd_active;
    logic rev_active;
    logic hs_own;
    logic mode_apply;
    logic [2:0] wmode;
    logic fifo_full;
    logic fifo_empty;
    logic [8:0] fifo_q;
    logic fifo_push;
    logic [8:0] fifo_din;
    logic fifo_pop;
    logic fifo_flush;
    logic bus_push;
    logic [8:0] bus_din;
    logic bus_pop;
    logic fsm_pop;
    logic fsm_push;
    logic [3:0] ctl_level;

    assign idx = paddr[ADDR_W-1:2];
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite && hit;
    assign rd_acc = psel && penable && !pwrite && hit;
    assign pslverr = psel && penable && !hit;
    assign prdata = {24'h000000, prdata_reg};
    assign wmode = pwdata[ECR_MODE_LSB +: 3];

    // direction forced out in 000 and 010
    assign dir_eff = (mode_reg == MODE_STD || mode_reg == MODE_FIFO) ? 1'b0 :
                     ctrl_reg[CTRL_DIR_BIT];
    assign fwd_active = (mode_reg == MODE_FIFO) || (mode_reg == MODE_ECP && !dir_eff);
    assign rev_active = (mode_reg == MODE_ECP) && dir_eff;
    assign hs_own = (mode_reg == MODE_FIFO) || (mode_reg == MODE_ECP);
    assign epp_active = (mode_reg == MODE_EPP) && epp_opt_reg;

    always_comb begin
        hit = 1'b0;
        unique case (idx)
            IDX_DATA, IDX_STATUS, IDX_CTRL, IDX_ECR, IDX_OPT: hit = 1'b1;
            IDX_FIFO: hit = (mode_reg == MODE_FIFO) || (mode_reg == MODE_ECP) ||
                            (mode_reg == MODE_TEST) || (mode_reg == MODE_CFG);
            IDX_CFGB: hit = (mode_reg == MODE_CFG);
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        rd_val = 8'h00;
        unique case (idx)
            IDX_DATA: rd_val = (mode_reg == MODE_PS2) ? pd_i : data_reg;
            IDX_STATUS: rd_val = {~busy_i, nack_i, perror_i, select_i, nfault_i, 3'h0};
            IDX_CTRL: rd_val = {2'h0, ctrl_reg};
            IDX_FIFO: begin
                if (mode_reg == MODE_CFG) begin
                    rd_val = CFGA_VALUE;
                end else begin
                    // empty queue rereads the last byte taken
                    rd_val = fifo_empty ? last_rd_reg : fifo_q[7:0];
                end
            end
            IDX_CFGB: rd_val = {1'b0, CFGB_VALUE[6:0]};
            IDX_ECR: rd_val = {mode_reg, ecr_misc_reg, fifo_full, fifo_empty};
            IDX_OPT: rd_val = {7'h00, epp_opt_reg};
            default: rd_val = 8'h00;
        endcase
    end

    // read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata_reg <= 8'h00;
            cap_empty_reg <= 1'b1;
        end else if (psel && !penable) begin
            prdata_reg <= hit ? rd_val : 8'h00;
            cap_empty_reg <= fifo_empty;
        end
    end

    // bus side of the queue
    always_comb begin
        bus_push = 1'b0;
        bus_din = {TAG_DATA, pwdata[7:0]};
        if (wr_acc && pstrb[0]) begin
            if (idx == IDX_DATA && mode_reg == MODE_ECP && !dir_eff) begin
                bus_push = 1'b1;
                bus_din = {TAG_CMD, pwdata[7:0]};
            end else if (idx == IDX_FIFO) begin
                bus_push = fwd_active || (mode_reg == MODE_TEST);
            end
        end
    end
    assign bus_pop = rd_acc && idx == IDX_FIFO && !cap_empty_reg &&
                     ((mode_reg == MODE_TEST) || rev_active);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            last_rd_reg <= 8'h00;
        end else if (bus_pop) begin
            last_rd_reg <= fifo_q[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data_reg <= DATA_RST;
        end else if (wr_acc && pstrb[0] && idx == IDX_DATA && epm_is_basic(mode_reg)) begin
            data_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_acc && pstrb[0] && idx == IDX_CTRL) begin
            ctrl_reg[4:0] <= pwdata[4:0];
            if (mode_reg == MODE_PS2) begin
                ctrl_reg[CTRL_DIR_BIT] <= pwdata[CTRL_DIR_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            epp_opt_reg <= OPT_EPP_RST;
            ecr_misc_reg <= ECR_MISC_RST;
        end else if (wr_acc && pstrb[0]) begin
            if (idx == IDX_OPT) begin
                epp_opt_reg <= pwdata[OPT_EPP_BIT];
            end
            if (idx == IDX_ECR) begin
                ecr_misc_reg <= pwdata[ECR_MISC_LSB +: 3];
            end
        end
    end

    // a switch back waits until the handshake lines rest deasserted
    assign mode_apply = pend_valid_reg && st_reg == HS_IDLE &&
                        strobe_pin_reg && autofd_pin_reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= ECR_MODE_RST;
            pend_mode_reg <= ECR_MODE_RST;
            pend_valid_reg <= 1'b0;
            flush_reg <= 1'b0;
        end else begin
            flush_reg <= mode_apply;
            if (mode_apply) begin
                mode_reg <= pend_mode_reg;
                pend_valid_reg <= 1'b0;
            end else if (wr_acc && pstrb[0] && idx == IDX_ECR && !pend_valid_reg) begin
                if (epm_is_basic(mode_reg)) begin
                    mode_reg <= wmode;
                end else if (epm_is_basic(wmode)) begin
                    pend_mode_reg <= wmode;
                    pend_valid_reg <= 1'b1;
                end
                // any other target is dropped
            end
        end
    end

    assign fifo_flush = (mode_reg == MODE_STD) || flush_reg;
    assign fsm_pop = st_reg == HS_IDLE && !pend_valid_reg && fwd_active &&
                     !fifo_empty && !busy_i;
    // reverse command bytes are not queued; only data bytes with periphack high are pushed
    assign fsm_push = st_reg == HS_IDLE && !pend_valid_reg && rev_active &&
                      !autofd_pin_reg && !nack_i && busy_i && !fifo_full;
    assign fifo_push = fsm_push || bus_push;
    assign fifo_din = fsm_push ? {TAG_DATA, pd_i} : bus_din;
    assign fifo_pop = fsm_pop || bus_pop;

    epm_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .flush(fifo_flush),
        .push(fifo_push),
        .push_data(fifo_din),
        .pop(fifo_pop),
        .pop_data(fifo_q),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_reg <= HS_IDLE;
            strobe_pin_reg <= 1'b1;
            autofd_pin_reg <= 1'b1;
            timer_reg <= 8'h00;
            pd_out_reg <= DATA_RST;
        end else if (pend_valid_reg && rev_active) begin
            autofd_pin_reg <= 1'b1;
            strobe_pin_reg <= 1'b1;
            st_reg <= HS_IDLE;
        end else begin
            unique case (st_reg)
                HS_IDLE: begin
                    if (!hs_own) begin
                        pd_out_reg <= data_reg;
                    end
                    if (pend_valid_reg) begin
                        strobe_pin_reg <= 1'b1;
                        autofd_pin_reg <= 1'b1;
                    end else if (fsm_pop) begin
                        pd_out_reg <= fifo_q[7:0];
                        // hostack level carries the tag in ecp
                        autofd_pin_reg <= (mode_reg == MODE_ECP) ? fifo_q[8] : 1'b1;
                        timer_reg <= 8'(HS_SETUP_CYC - 1);
                        st_reg <= HS_SETUP;
                    end else if (rev_active) begin
                        if (!autofd_pin_reg && !nack_i) begin
                            autofd_pin_reg <= 1'b1;
                            st_reg <= HS_REV_ACK;
                        end else if (autofd_pin_reg && !fifo_full) begin
                            autofd_pin_reg <= 1'b0;
                        end
                    end
                end
                HS_SETUP: begin
                    if (timer_reg == 8'h00) begin
                        strobe_pin_reg <= 1'b0;
                        timer_reg <= 8'(HS_STROBE_CYC - 1);
                        st_reg <= HS_STROBE;
                    end else begin
                        timer_reg <= timer_reg - 8'h01;
                    end
                end
                HS_STROBE: begin
                    if (timer_reg != 8'h00) begin
                        timer_reg <= timer_reg - 8'h01;
                    end
                    // ecp waits for the peripheral, compatible mode for the pulse width
                    if ((mode_reg == MODE_ECP) ? busy_i : (timer_reg == 8'h00)) begin
                        strobe_pin_reg <= 1'b1;
                        st_reg <= HS_RELEASE;
                    end
                end
                HS_RELEASE: begin
                    if (!busy_i) begin
                        st_reg <= HS_IDLE;
                    end
                end
                HS_REV_ACK: begin
                    if (nack_i) begin
                        st_reg <= HS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pd_oe_reg <= 1'b1;
        end else begin
            pd_oe_reg <= !dir_eff;
        end
    end
    assign pd_o = pd_out_reg;
    assign pd_oe = pd_oe_reg;

    assign ctl_level[0] = hs_own ? strobe_pin_reg : !ctrl_reg[CTRL_STROBE_BIT];
    assign ctl_level[1] = hs_own ? autofd_pin_reg : !ctrl_reg[CTRL_AUTOFD_BIT];
    assign ctl_level[2] = ctrl_reg[CTRL_INIT_BIT];
    assign ctl_level[3] = !ctrl_reg[CTRL_SELIN_BIT];

    epm_pin_drive u_pins (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .open_collector(mode_reg == MODE_STD),
        .level(ctl_level),
        .pin_o(ctl_o),
        .pin_oe(ctl_oe)
    );
endmodule : epm_ctrl

//--- hw/epm_fifo.sv
// tagged byte queue shared by the command and data ports
`timescale 1ns/1ps
module epm_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] pop_data,
    output logic full,
    output logic empty
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic do_push;
    logic do_pop;

    assign full = (count_reg == DEPTH_C);
    assign empty = (count_reg == '0);
    assign do_push = push && !full && !flush;
    assign do_pop = pop && !empty && !flush;
    assign pop_data = mem[rd_ptr_reg];

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : ptr_inc

    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (do_pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : epm_fifo

//--- hw/epm_pin_drive.sv
// registered open-collector or push-pull drive of the four control lines
`timescale 1ns/1ps
module epm_pin_drive
    import epm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic open_collector,
    input wire logic [3:0] level,
    output logic [3:0] pin_o,
    output logic [3:0] pin_oe
);
    // registered so that a mode switch between equal levels cannot glitch a line
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_o <= PIN_OUT_RST;
            pin_oe <= PIN_OE_RST;
        end else if (open_collector) begin
            pin_o <= 4'h0;
            pin_oe <= ~level;
        end else begin
            pin_o <= level;
            pin_oe <= 4'hF;
        end
    end
endmodule : epm_pin_drive

//--- test/epm_ctrl_sva.sv
// port checker for the extended parallel port mode control
`timescale 1ns/1ps
module epm_ctrl_sva
    import epm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [epm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] pd_o,
    input wire logic pd_oe,
    input wire logic [3:0] ctl_o,
    input wire logic [3:0] ctl_oe,
    input wire logic perror_i,
    input wire logic select_i,
    input wire logic nfault_i
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    logic [10:0] idx;
    logic acc;
    assign idx = paddr[12:2];
    assign acc = psel && penable;
    a_ready_always: assert property (pready) else $error("pready low");
    a_err_access: assert property (pslverr |-> acc) else $error("slverr outside access");
    a_rdata_hold:
        assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
    a_status_read:
        assert property (psel && !penable && !pwrite && idx == IDX_STATUS
            |=> prdata[5:3] == $past({perror_i, select_i, nfault_i})) else $error("status bits");
    a_fixed_map:
        assert property (acc && (idx <= IDX_CTRL || (idx >= IDX_ECR && idx <= IDX_OPT))
            |-> !pslverr) else $error("mapped register refused");
    a_hole_refused:
        assert property (acc && (idx > IDX_OPT || (idx > IDX_CTRL && idx < IDX_FIFO))
            |-> pslverr && prdata == 32'h0) else $error("unmapped access accepted");
    a_oc_drive:
        assert property (ctl_oe != 4'hF |-> ctl_o == 4'h0) else $error("open collector drive");
    a_reset_pins:
        assert property ($rose(rstn) |-> ctl_oe == PIN_OE_RST && ctl_o == PIN_OUT_RST && pd_oe)
            else $error("pins after reset");
    a_strobe_setup:
        assert property ($fell(ctl_o[0]) && ctl_oe[0] |-> $past(pd_o, 8) == pd_o)
            else $error("strobe before data settled");
endmodule : epm_ctrl_sva
bind epm_ctrl epm_ctrl_sva i_epm_ctrl_sva (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pd_o(pd_o), .pd_oe(pd_oe), .ctl_o(ctl_o), .ctl_oe(ctl_oe),
    .perror_i(perror_i), .select_i(select_i), .nfault_i(nfault_i));

//--- test/epm_ctrl_tb_top.sv
// self-checking bench for the extended parallel port mode control
`timescale 1ns/1ps
module epm_ctrl_tb_top;
    import epm_pkg::*;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, pd_oe, busy_i, nack_i, epp_active, err;
    logic perror_i = 1'h0;
    logic select_i = 1'h0;
    logic nfault_i = 1'h0;
    logic slow = 1'h0;
    logic rev_go = 1'h0;
    logic [7:0] rev_byte = 8'h00;
    logic [7:0] pd_i, pd_o, rd, b0, b1;
    logic [7:0] q [16];
    logic [3:0] ctl_o, ctl_oe;
    logic [17:0] fwd_hist;
    int fwd_cnt, rev_cnt, f0;
    int error_cnt = 0;
    int check_count = 0;
    int seed = 60295;
    int cyc = 0;
    always #(CLK_PERIOD_NS / 2.0) clk_sys = ~clk_sys;
    epm_ctrl #(.FIFO_DEPTH(16), .CFGB_VALUE(8'h00)) i_epm_ctrl (.clk_sys(clk_sys), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pd_i(pd_i),
        .pd_o(pd_o), .pd_oe(pd_oe), .ctl_o(ctl_o), .ctl_oe(ctl_oe), .busy_i(busy_i),
        .nack_i(nack_i), .perror_i(perror_i), .select_i(select_i), .nfault_i(nfault_i),
        .epp_active(epp_active));
    epm_periph_model i_epm_periph_model (.clk_sys(clk_sys), .pd_o(pd_o), .pd_oe(pd_oe),
        .ctl_o(ctl_o), .ctl_oe(ctl_oe), .slow(slow), .rev_go(rev_go), .rev_byte(rev_byte),
        .pd_i(pd_i), .busy_i(busy_i), .nack_i(nack_i), .fwd_hist(fwd_hist),
        .fwd_cnt(fwd_cnt), .rev_cnt(rev_cnt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [10:0] i, input logic [7:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        @(posedge clk_sys);
        while (!pready) @(posedge clk_sys);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask : apb
    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    // bound on the whole run, well above the longest handshake sequence
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'h1;
        @(posedge clk_sys);
        apb(1'h0, IDX_ECR, 8'h00);
        chk(rd, 8'h01);
        apb(1'h0, IDX_CFGB, 8'h00);
        chk(err, 1'h1);
        apb(1'h0, 11'h010, 8'h00);
        chk({err, rd}, 9'h100);
        {perror_i, select_i, nfault_i} <= 3'($random(seed));
        repeat (3) @(posedge clk_sys);
        apb(1'h0, IDX_STATUS, 8'h00);
        chk(rd, {2'h3, perror_i, select_i, nfault_i, 3'h0});
        apb(1'h1, IDX_CTRL, 8'h20);
        apb(1'h0, IDX_CTRL, 8'h00);
        chk({pd_oe, rd}, 9'h100);
        apb(1'h1, IDX_ECR, 8'h20);
        rev_byte <= 8'($random(seed));
        rev_go <= 1'h1;
        apb(1'h1, IDX_CTRL, 8'h20);
        apb(1'h0, IDX_DATA, 8'h00);
        chk({pd_oe, rd}, {1'h0, rev_byte});
        apb(1'h1, IDX_ECR, 8'h60);
        while (rev_cnt < 17) @(posedge clk_sys);
        apb(1'h0, IDX_ECR, 8'h00);
        chk(rd, 8'h62);
        for (int k = 0; k < 16; k++) begin
            apb(1'h0, IDX_FIFO, 8'h00);
            chk(rd, rev_byte ^ 8'(k + (k > 2)));
        end
        apb(1'h1, IDX_ECR, 8'h20);
        repeat (3) @(posedge clk_sys);
        chk({ctl_oe[1], ctl_o[1]}, 2'h3);
        rev_go <= 1'h0;
        apb(1'h0, IDX_ECR, 8'h00);
        chk(rd, 8'h21);
        apb(1'h1, IDX_CTRL, 8'h00);
        apb(1'h1, IDX_ECR, 8'hE0);
        apb(1'h0, IDX_FIFO, 8'h00);
        chk(rd, 8'h10);
        apb(1'h0, IDX_CFGB, 8'h00);
        chk({err, rd}, 9'h000);
        apb(1'h1, IDX_ECR, 8'h20);
        apb(1'h1, IDX_ECR, 8'hC0);
        apb(1'h1, IDX_ECR, 8'h60);
        apb(1'h0, IDX_ECR, 8'h00);
        chk(rd, 8'hC1);
        f0 = fwd_cnt;
        for (int k = 0; k < 17; k++) begin
            b0 = 8'($random(seed));
            if (k < 16) q[k] = b0;
            apb(1'h1, IDX_FIFO, b0);
        end
        apb(1'h0, IDX_ECR, 8'h00);
        chk(rd, 8'hC2);
        for (int k = 0; k < 16; k++) begin
            apb(1'h0, IDX_FIFO, 8'h00);
            chk(rd, q[k]);
        end
        apb(1'h0, IDX_FIFO, 8'h00);
        chk(rd, q[15]);
        apb(1'h0, IDX_ECR, 8'h00);
        chk({rd, 8'(fwd_cnt - f0)}, 16'hC100);
        apb(1'h1, IDX_ECR, 8'h00);
        apb(1'h1, IDX_ECR, 8'h40);
        slow <= 1'($random(seed));
        for (int k = 0; k < 3; k++) begin
            b1 = b0;
            b0 = 8'($random(seed));
            apb(1'h1, IDX_FIFO, b0);
        end
        while (fwd_cnt < f0 + 3) @(posedge clk_sys);
        chk(fwd_hist, {1'h1, b1, 1'h1, b0});
        apb(1'h1, IDX_ECR, 8'h00);
        apb(1'h1, IDX_CTRL, 8'h04);
        apb(1'h1, IDX_ECR, 8'h60);
        b1 = {1'h0, 7'($random(seed))};
        b0 = 8'($random(seed));
        apb(1'h1, IDX_DATA, b1);
        apb(1'h1, IDX_FIFO, b0);
        while (fwd_cnt < f0 + 5) @(posedge clk_sys);
        chk(fwd_hist, {1'h0, b1, 1'h1, b0});
        apb(1'h1, IDX_ECR, 8'h00);
        apb(1'h0, IDX_ECR, 8'h00);
        chk({rd, ctl_oe[1:0]}, 10'h004);
        apb(1'h1, IDX_DATA, b1);
        apb(1'h0, IDX_DATA, 8'h00);
        chk(rd, b1);
        apb(1'h1, IDX_ECR, 8'h80);
        chk(epp_active, 1'h0);
        apb(1'h1, IDX_ECR, 8'h00);
        apb(1'h1, IDX_OPT, 8'h01);
        apb(1'h1, IDX_ECR, 8'h80);
        chk(epp_active, 1'h1);
        apb(1'h1, IDX_ECR, 8'h00);
        apb(1'h1, IDX_ECR, 8'hA0);
        apb(1'h0, IDX_FIFO, 8'h00);
        chk({err, epp_active}, 2'h2);
        results();
    end
endmodule : epm_ctrl_tb_top

//--- test/epm_periph_model.sv
// peripheral model on the parallel port pins
`timescale 1ns/1ps
module epm_periph_model (
    input wire logic clk_sys,
    input wire logic [7:0] pd_o,
    input wire logic pd_oe,
    input wire logic [3:0] ctl_o,
    input wire logic [3:0] ctl_oe,
    input wire logic slow,
    input wire logic rev_go,
    input wire logic [7:0] rev_byte,
    output logic [7:0] pd_i,
    output logic busy_i,
    output logic nack_i,
    output logic [17:0] fwd_hist,
    output int fwd_cnt,
    output int rev_cnt
);
    logic [3:0] pin;
    // control lines have pull-ups when released
    assign pin = ~ctl_oe | ctl_o;
    // released data lines show the inverse of the host's last value unless rev_go drives a reverse byte
    // the fourth reverse transfer is a command, so its top bit is forced low
    assign pd_i = pd_oe ? pd_o :
                  (rev_go ? (rev_byte ^ rev_cnt[7:0]) & {rev_cnt != 3, 7'h7F} : ~pd_o);
    initial begin
        busy_i = 1'h0;
        nack_i = 1'h1;
        fwd_hist = '0;
        fwd_cnt = 0;
        rev_cnt = 0;
        forever begin
            @(posedge clk_sys);
            if (rev_go && !pin[1]) begin
                // periphack stays low for the command, which the port must drop
                busy_i <= (rev_cnt != 3);
                @(posedge clk_sys);
                nack_i <= 1'h0;
                while (!pin[1]) @(posedge clk_sys);
                nack_i <= 1'h1;
                busy_i <= 1'h0;
                rev_cnt <= rev_cnt + 1;
            end else if (!rev_go && !pin[0] && !busy_i) begin
                fwd_hist <= {fwd_hist[8:0], pin[1], pd_o};
                repeat (slow ? 6 : 1) @(posedge clk_sys);
                busy_i <= 1'h1;
                while (!pin[0]) @(posedge clk_sys);
                busy_i <= 1'h0;
                fwd_cnt <= fwd_cnt + 1;
            end
        end
    end
endmodule : epm_periph_model
